//--- src_params.svh
`ifndef SRC_PARAMS_SVH
`define SRC_PARAMS_SVH

// Display range of the reading and of every threshold.
`define SRC_RANGE_MAX      15'sd9999
`define SRC_RANGE_MIN      -15'sd1999

// Make and break delays are whole seconds, 0 to 9999.
`define SRC_DELAY_MAX      14'd9999

// Threshold reset state: parked at the top in high mode, so inactive.
`define SRC_SP_RST_VALUE   15'sd9999
`define SRC_SP_RST_HIGH    1'b1
`define SRC_SP_RST_HYSTERESIS_ENABLE    1'b0
`define SRC_DELAY_RST      14'd0
`define SRC_PUMP_RST       1'b0

// Hysteresis band width in counts when enabled.
`define SRC_HYSTERESIS_ENABLE_COUNTS    16'sd2

// Delay tick: one second at the 250 MHz system clock.
`define SRC_TICK_SECONDS   1
`define SRC_CLK_HZ         250000000
`define SRC_TICK_CYCLES    (`SRC_TICK_SECONDS * `SRC_CLK_HZ)

`endif

//--- src_pkg.sv
package src_pkg;

   // Configuration of one threshold.
   typedef struct packed {
      logic signed [14:0] value;
      logic               high_mode;
      logic               hysteresis_enable;
   } src_sp_cfg_t;

   // Configuration of the first threshold's timers and pump mode.
   typedef struct packed {
      logic [13:0] make_delay;
      logic [13:0] break_delay;
      logic        pump_mode_enable;
   } src_tmr_cfg_t;

   typedef enum logic [1:0] {
      SRC_SEL_ONE,
      SRC_SEL_TWO,
      SRC_SEL_THREE,
      SRC_SEL_FOUR
   } src_sel_t;

endpackage

//--- src_setpoint_relay_controller.sv
`include "src_params.svh"

// Behaviour
// - All four thresholds evaluated regardless of fitted relays.
// - Signed thresholds; parked extremes never activate.
// - Relay one makes after continuous alarm delay.
// - Relay one breaks after continuous non-alarm delay.
// - Thresholds two to four follow comparison directly.
// - Every threshold has its own hysteresis enable.
// - Pump mode bands relay one between thresholds.
// - Pump low mode: on below one, off at two.
// - Pump high mode: on above two, off at one.
// - High mode energizes above, low mode below.
// - Lock input blocks every configuration change.
module src_setpoint_relay_controller #(
   parameter int unsigned TICK_CYCLES = `SRC_TICK_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic signed [14:0]        reading,
   input  wire logic                      lock_n,
   input  wire logic                      sp_wr,
   input  wire src_pkg::src_sel_t         sp_sel,
   input  wire src_pkg::src_sp_cfg_t      sp_data,
   input  wire logic                      tmr_wr,
   input  wire src_pkg::src_tmr_cfg_t     tmr_data,
   output src_pkg::src_sp_cfg_t [3:0]     sp_view,
   output src_pkg::src_tmr_cfg_t          tmr_view,
   output logic [3:0]                     relay,
   output logic [3:0]                     led
);

   logic                     lock_meta;
   logic                     lock_sync_n;
   src_pkg::src_sp_cfg_t     sp_cfg [4];
   src_pkg::src_tmr_cfg_t    tmr_cfg;
   logic [3:0]               cmp;
   logic                     relay_one;
   logic [13:0]              delay_cnt;
   logic [31:0]              tick_cnt;
   logic                     tick;

   // Reading and thresholds are 15 bits signed: 14 bits would stop at 8191
   // and could not hold the top of the display range, so a threshold parked
   // there would be unreachable in storage rather than in comparison.
   // The lock pin comes from a rear-panel switch, so it is synchronised first.
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         lock_meta   <= 1'b1;
         lock_sync_n <= 1'b1;
      end
      else
      begin
         lock_meta   <= lock_n;
         lock_sync_n <= lock_meta;
      end
   end

   // Reset leaves the synchroniser unlocked, so writes are taken straight
   // after reset; a held lock pin needs two cycles before it blocks writes.
   wire locked = !lock_sync_n;
   wire sp_wr_ok = sp_wr && !locked;
   wire tmr_wr_ok = tmr_wr && !locked;

   // Written thresholds are clamped to the display range, so a parked value
   // at either end can never be crossed by a legal reading.
   wire signed [14:0] sp_clamped =
      (sp_data.value > `SRC_RANGE_MAX) ? `SRC_RANGE_MAX :
      (sp_data.value < `SRC_RANGE_MIN) ? `SRC_RANGE_MIN : sp_data.value;
   // Delays are clamped too, since the field can hold more than the maximum.
   wire [13:0] make_clamped =
      (tmr_data.make_delay > `SRC_DELAY_MAX) ? `SRC_DELAY_MAX : tmr_data.make_delay;
   wire [13:0] break_clamped =
      (tmr_data.break_delay > `SRC_DELAY_MAX) ? `SRC_DELAY_MAX : tmr_data.break_delay;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < 4; i++)
         begin
            sp_cfg[i].value             <= `SRC_SP_RST_VALUE;
            sp_cfg[i].high_mode         <= `SRC_SP_RST_HIGH;
            sp_cfg[i].hysteresis_enable <= `SRC_SP_RST_HYSTERESIS_ENABLE;
         end
      end
      else if (sp_wr_ok)
      begin
         sp_cfg[sp_sel].value             <= sp_clamped;
         sp_cfg[sp_sel].high_mode         <= sp_data.high_mode;
         sp_cfg[sp_sel].hysteresis_enable <= sp_data.hysteresis_enable;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         tmr_cfg.make_delay       <= `SRC_DELAY_RST;
         tmr_cfg.break_delay      <= `SRC_DELAY_RST;
         tmr_cfg.pump_mode_enable <= `SRC_PUMP_RST;
      end
      // Pump mode and both delays are written together as one word.
      else if (tmr_wr_ok)
      begin
         tmr_cfg.make_delay       <= make_clamped;
         tmr_cfg.break_delay      <= break_clamped;
         tmr_cfg.pump_mode_enable <= tmr_data.pump_mode_enable;
      end
   end

   // The views are the live registers, so a locked panel still reads every setting.
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         sp_view[i] = sp_cfg[i];
      end
   end

   assign tmr_view = tmr_cfg;

   // Comparisons run in 16 bits so that threshold plus band cannot wrap.
   wire signed [15:0] rd   = 16'(reading);
   wire signed [15:0] sp_1 = 16'(sp_cfg[0].value);
   wire signed [15:0] sp_2 = 16'(sp_cfg[1].value);
   wire pump_active = tmr_cfg.pump_mode_enable && (sp_2 > sp_1);

   // Every threshold is evaluated whether or not a relay is fitted to it.
   for (genvar g = 0; g < 4; g++)
   begin : g_cmp
      wire signed [15:0] sp   = 16'(sp_cfg[g].value);
      wire signed [15:0] band = sp_cfg[g].hysteresis_enable ? `SRC_HYSTERESIS_ENABLE_COUNTS : 16'sd0;
      wire hi = sp_cfg[g].high_mode;
      wire pump = (g == 0) && pump_active;
      // High mode: set above the threshold, clear at or below it less band.
      // Low mode: set below the threshold, clear at or above it plus band.
      wire set_std = hi ? (rd > sp) : (rd < sp);
      wire clr_std = hi ? (rd <= sp - band) : (rd >= sp + band);
      // Pump mode: threshold one is the lower limit, two the upper limit.
      wire set_pump = hi ? (rd > sp_2) : (rd < sp_1);
      wire clr_pump = hi ? (rd <= sp_1) : (rd >= sp_2);
      // Set wins over clear, so a reading that meets both keeps the output on.
      wire set_c = pump ? set_pump : set_std;
      wire clr_c = pump ? clr_pump : clr_std;

      always_ff @(posedge clk)
      begin
         if (!rstn)
         begin
            cmp[g] <= 1'b0;
         end
         else if (set_c)
         begin
            cmp[g] <= 1'b1;
         end
         else if (clr_c)
         begin
            cmp[g] <= 1'b0;
         end
      end
   end

   // Free-running one-second tick; a delay may therefore end up to one tick
   // early, the price of sharing one prescaler.
   // Thirty-two bits cover the one-second count at the full system clock.
   assign tick = (tick_cnt == TICK_CYCLES - 1);

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         tick_cnt <= 32'h0000_0000;
      end
      else if (tick)
      begin
         tick_cnt <= 32'h0000_0000;
      end
      else
      begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   // Relay one follows its alarm only once the alarm has differed from the
   // relay state for the whole programmed delay; any return restarts it.
   // The delay is compared live, so a new value written during a wait
   // takes effect at once instead of after the running wait ends.
   wire [13:0] delay_target = cmp[0] ? tmr_cfg.make_delay : tmr_cfg.break_delay;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         relay_one <= 1'b0;
         delay_cnt <= 14'h0000;
      end
      else if (cmp[0] == relay_one)
      begin
         delay_cnt <= 14'h0000;
      end
      else if (delay_cnt >= delay_target)
      begin
         relay_one <= cmp[0];
         delay_cnt <= 14'h0000;
      end
      else if (tick)
      begin
         delay_cnt <= delay_cnt + 14'h0001;
      end
   end

   // Thresholds two to four carry no timers; their outputs are the
   // comparison registers themselves.
   assign relay = {cmp[3], cmp[2], cmp[1], relay_one};
   assign led   = relay;

endmodule // src_setpoint_relay_controller

//--- src_relay_checker.sv
module src_relay_checker (
   input wire logic                         clk,
   input wire logic                         rstn,
   input wire logic signed [14:0]           reading,
   input wire logic                         lock_n,
   input wire src_pkg::src_sp_cfg_t [3:0]   sp_view,
   input wire src_pkg::src_tmr_cfg_t        tmr_view,
   input wire logic [3:0]                   relay,
   input wire logic [3:0]                   led
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire signed [15:0] rd = reading;
   wire signed [15:0] s1 = sp_view[0].value;
   wire signed [15:0] s2 = sp_view[1].value;
   wire signed [15:0] bd = sp_view[0].hysteresis_enable ? 16'sh2 : 16'sh0;
   wire               hi = sp_view[0].high_mode;
   wire               pmp = tmr_view.pump_mode_enable && (s2 > s1);
   wire               set1 = pmp ? (hi ? rd > s2 : rd < s1) : (hi ? rd > s1 : rd < s1);
   wire               clr1 = pmp ? (hi ? rd <= s1 : rd >= s2) : (hi ? rd <= s1 - bd : rd >= s1 + bd);
   wire               fast = tmr_view.make_delay == 14'h0 && tmr_view.break_delay == 14'h0;
   // Delay bounds are only meaningful without a band, where the alarm tracks set1 exactly.
   wire               plain = !pmp && !sp_view[0].hysteresis_enable;
   sequence s_on; set1 && fast; endsequence
   sequence s_off; clr1 && !set1 && fast; endsequence
   AST_LED: assert property (led == relay) else $error("led differs");
   AST_RST: assert property (disable iff (1'b0) !rstn |=> relay == 4'h0 && led == 4'h0)
      else $error("not cleared");
   AST_ONE_ON: assert property (s_on ##1 s_on |=> relay[0]) else $error("one on");
   AST_ONE_OFF: assert property (s_off ##1 s_off |=> !relay[0]) else $error("one off");
   AST_THREE: assert property (sp_view[2].high_mode && rd > sp_view[2].value |=> relay[2])
      else $error("three");
   AST_FOUR: assert property (!sp_view[3].high_mode && rd < sp_view[3].value |=> relay[3])
      else $error("four");
   AST_PARK: assert property (sp_view[1].high_mode && sp_view[1].value == 15'h270f && !relay[1]
      |=> !relay[1]) else $error("parked");
   AST_MAKE: assert property ($rose(set1) && plain && !relay[0] && tmr_view.make_delay == 14'h2
      |=> !relay[0] [*8]) else $error("make early");
   AST_BREAK: assert property ($fell(set1) && plain && relay[0] && tmr_view.break_delay == 14'h2
      |=> relay[0] [*8]) else $error("break early");
   AST_LOCK: assert property (!lock_n [*4] |=> $stable(sp_view) && $stable(tmr_view))
      else $error("locked write");
endmodule // src_relay_checker

//--- src_panel_model.sv
module src_panel_model (
   input  wire logic       clk,
   input  wire logic [3:0] relay,
   input  wire logic [3:0] led,
   output logic [3:0]      coil,
   output logic [3:0]      lamp
);
   timeunit 1ns;
   timeprecision 1ps;
   // Coils pull in a clock after the drive; contact bounce is not modelled.
   always_ff @(posedge clk) coil <= relay;
   assign lamp = led;
endmodule // src_panel_model

//--- testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       clk = 1'h0, rstn = 1'h0, lock_n = 1'h1, sp_wr = 1'h0, tmr_wr = 1'h0;
   logic signed [14:0]         reading = 15'h0;
   src_pkg::src_sel_t          sp_sel = src_pkg::SRC_SEL_ONE;
   src_pkg::src_sp_cfg_t       sp_data = 17'h0;
   src_pkg::src_tmr_cfg_t      tmr_data = 29'h0;
   src_pkg::src_sp_cfg_t [3:0] sp_view;
   src_pkg::src_tmr_cfg_t      tmr_view;
   logic [3:0]                 relay, led;
   logic [7:0]                 q[$];
   int                         n_mismatch = 0, num_checks = 0, seed = 9, i;
   src_setpoint_relay_controller #(.TICK_CYCLES(10)) u_dut (.*);
   src_panel_model u_panel (.clk(clk), .relay(relay), .led(led), .coil(), .lamp());
   initial forever #2 clk = ~clk;
   task automatic w(input int n); repeat (n) @(negedge clk); endtask
   task automatic ex(input logic [3:0] r); q.push_back({r, r}); w(1); endtask
   task automatic rd(input logic [14:0] v, input int n); reading = v; w(n); endtask
   task automatic sp(input int k, input logic [14:0] v, input logic h, input logic y);
      sp_sel = src_pkg::src_sel_t'(k);
      sp_data = {v, h, y};
      sp_wr = 1'h1;
      w(1);
      sp_wr = 1'h0;
      w(1);
   endtask
   task automatic tm(input logic [13:0] mk, input logic [13:0] bk, input logic p);
      tmr_data = {mk, bk, p};
      tmr_wr = 1'h1;
      w(1);
      tmr_wr = 1'h0;
      w(1);
   endtask
   task automatic cmp(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Results are taken just after the edge so that registered outputs have settled.
   always @(posedge clk) if (q.size() > 0) begin #1 cmp({led, relay}, q.pop_front()); end
   initial begin #100000; n_mismatch++; end_sim; end
   initial
   begin
      w(5);
      rstn = 1'h1;
      w(3);
      ex(4'h0);
      tm(14'h0, 14'h0, 1'h0);
      for (i = 0; i < 4; i++) sp(i, 14'h64, 1'h1, 1'h0);
      rd(14'h65, 3); ex(4'hf);
      rd(14'h64, 3); ex(4'h0);
      for (i = 0; i < 4; i++) sp(i, 14'h64, 1'h0, i[0]);
      rd(14'h63, 3); ex(4'hf);
      rd(14'h65, 3); ex(4'ha);
      rd(14'h66, 3); ex(4'h0);
      $display("test modes done");
      for (i = 0; i < 4; i++) sp(i, 14'h64, 1'h1, 1'h0);
      for (i = 0; i < 12; i++)
      begin
         rd(15'($random(seed) % 2000), 3); ex({4{reading > 15'sh64}});
      end
      $display("test random done");
      for (i = 1; i < 4; i++) sp(i, 14'h270f, 1'h1, 1'h0);
      tm(14'h2, 14'h2, 1'h0);
      rd(14'h0, 30); ex(4'h0);
      for (i = 0; i < 3; i++) begin rd(14'h65, 9); rd(14'h64, 1); end
      rd(14'h65, 8); ex(4'h0);
      rd(14'h65, 25); ex(4'h1);
      rd(14'h64, 9); ex(4'h1);
      rd(14'h65, 2); rd(14'h64, 9); ex(4'h1);
      rd(14'h64, 22); ex(4'h0);
      $display("test delays done");
      tm(14'h0, 14'h0, 1'h1);
      sp(0, 14'h64, 1'h0, 1'h0);
      sp(1, 14'hc8, 1'h1, 1'h0);
      rd(14'h96, 3); ex(4'h0);
      rd(14'h63, 3); ex(4'h1);
      rd(14'h96, 3); ex(4'h1);
      rd(14'hc8, 3); ex(4'h0);
      sp(0, 14'h64, 1'h1, 1'h0);
      rd(14'hc9, 3); ex(4'h3);
      rd(14'h96, 3); ex(4'h1);
      rd(14'h64, 3); ex(4'h0);
      $display("test pump done");
      tm(14'h0, 14'h0, 1'h0);
      lock_n = 1'h0;
      w(4);
      sp(0, 15'h7831, 1'h1, 1'h0);
      tm(14'h5, 14'h5, 1'h1);
      cmp(sp_view[0].value, 15'h64);
      cmp(tmr_view.make_delay, 14'h0);
      rd(15'h0, 3); ex(4'h0);
      lock_n = 1'h1;
      w(4);
      sp(0, 15'h7831, 1'h1, 1'h0);
      rd(15'h0, 3); ex(4'h1);
      sp(2, 15'h3fff, 1'h1, 1'h0);
      tm(14'h3fff, 14'h0, 1'h0);
      cmp(sp_view[2].value, 15'h270f);
      cmp(tmr_view.make_delay, 14'h270f);
      $display("test lock done");
      w(3);
      end_sim;
   end
endmodule // testbench
bind src_setpoint_relay_controller src_relay_checker u_chk (.*);
